/* File: core/tcm_pkg.sv */
package tcm_pkg;

    // ****************************************
    // Register addresses of the config port
    // ****************************************
    localparam logic [5:0] TCM_ADDR_TOP_TEST = 6'h2F;
    localparam logic [5:0] TCM_ADDR_SPARE = 6'h30;
    localparam logic [5:0] TCM_ADDR_TX_FIFO = 6'h3E;
    localparam logic [5:0] TCM_ADDR_RX_FIFO = 6'h3F;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int TCM_BIT_SELFTEST = 7;
    localparam int TCM_BIT_BATT = 6;
    localparam int TCM_BIT_NODE_DRIVE = 5;
    localparam int TCM_BIT_PROBE_PD = 4;
    localparam logic [15:0] TCM_TOP_TEST_RST = 16'h0010;
    localparam logic [15:0] TCM_SPARE_RST = 16'h0000;
    localparam logic [4:0] TCM_SEL_RST = 5'h00;
    localparam logic [3:0] TCM_PROBE_NODE_MODE = 4'h7;
    localparam logic [3:0] TCM_PROBE_LAST_MODE = 4'h8;

    // ****************************************
    // Internal signals offered to the test pins
    // ****************************************
    typedef struct packed {
        logic assess_normal;
        logic adc_q_lsb;
        logic late_resync_pulse;
        logic lock_status;
        logic chip_rate_tick;
        logic bit_rate_tick;
        logic synth_off;
        logic converter_off;
        logic var_gain_amp_off;
        logic rx_bandpass_off;
        logic front_end_off;
        logic power_amp_off;
        logic gain_loop_tick;
        logic [1:0] stage_peak_flag;
        logic front_gain_level_b1;
        logic amp_gain_b1;
        logic peak_reset_n;
        logic half_rate_clock_out;
        logic crystal_settled;
        logic synth_reference_out;
        logic synth_divided_out;
        logic synth_lock_span;
        logic synth_lock_span_sync;
        logic adc_clock;
        logic delimiter_normal;
    } tcm_probe_s;

    // Analog probe module controls
    typedef struct packed {
        logic powered;
        logic [3:0] mode;
        logic node_drive;
        logic pin_b_is_output;
    } tcm_analog_s;

endpackage

/* File: core/tcm_test_control.sv */
`timescale 1ns/1ps
// How it works
// - Bit 7 of test control runs packet RAM self-test; result goes to frame delimiter pin.
// - Bit 6 routes battery monitor result to test output; resets zero.
// - In mode 7, bit 5 picks probe pin b direction: 0 watch, 1 drive.
// - Bit 4 powers down analog probe; resets to one.
// - Mode field 3:0 acts only when powered up; codes 0 to 8 used.
// - Spare 16-bit read/write register at 0x30, resets zero.
// - Transmit FIFO byte at 0x3E is write only.
// - Receive FIFO byte at 0x3F supports byte reads and writes.
// - Both status pins may carry a test signal, each with its own selector.
// - Assess selector 0 normal output, 1 ADC Q-branch LSB.
// - Selector 2 gives one-cycle pulse on each late demodulator resync.
// - Selector 3 shows synthesizer lock status.
// - Selectors 4 and 5 give chip-rate and bit-rate ticks.
// - Selectors 6 to 11 give the six power-down controls in order.
// - Selector 12 gives one-cycle pulse on each gain update.
// - Selectors 13 to 17 give peak flags, gain bits, peak reset.
// - Codes 18 to 22 reserved; 23 to 29 give clocks and lock signals.
module tcm_test_control
    import tcm_pkg::*;
#(
    parameter int ADDR_W = 6, // Config port address width
    parameter int REG_W = 16, // Config register width
    parameter int SEL_W = 5 // Test pin selector width
)
(
    input wire logic clk, // 16 MHz system clock
    input wire logic reset_n, // Asynchronous reset, active low
    input wire logic cfg_wr, // Register write strobe
    input wire logic cfg_rd, // Register read strobe
    input wire logic [ADDR_W-1:0] cfg_addr, // Register address
    input wire logic [REG_W-1:0] cfg_wdata, // Register write data
    output logic [REG_W-1:0] cfg_rdata, // Registered read data
    output logic cfg_hit, // Address belongs to this block
    input wire logic [SEL_W-1:0] assess_pin_selector, // Selector for assessment pin
    input wire logic [SEL_W-1:0] delimiter_pin_selector, // Selector for delimiter pin
    input wire tcm_probe_s probe, // Internal test signals
    input wire logic selftest_result, // Packet RAM self-test result
    input wire logic battery_result, // Battery monitor result
    input wire logic [7:0] rx_fifo_rdata, // Byte at receive FIFO head
    output logic packet_ram_selftest_go, // Self-test run level
    output logic battery_probe_out_en, // Battery result routed out
    output tcm_analog_s analog_ctrl, // Analog probe controls
    output logic tx_fifo_push, // Transmit FIFO byte write pulse
    output logic rx_fifo_push, // Receive FIFO byte write pulse
    output logic rx_fifo_pop, // Receive FIFO byte read pulse
    output logic [7:0] fifo_wdata, // Byte written to a FIFO
    output logic assess_pin, // Channel assessment pin level
    output logic frame_delimiter_pin // Frame delimiter pin level
);

    // ****************************************
    // Parameter checks
    // ****************************************
    // Address map, register layout and selector table fit these widths only
    if (ADDR_W != 6) begin
        $error("ADDR_W must be 6");
    end
    if (REG_W != 16) begin
        $error("REG_W must be 16");
    end
    if (SEL_W != 5) begin
        $error("SEL_W must be 5");
    end

    // ****************************************
    // Address decode
    // ****************************************
    logic hit_top;
    logic hit_spare;
    logic hit_tx;
    logic hit_rx;

    // Compare an address with one register's offset
    function automatic logic tcm_is(input logic [5:0] a, input logic [5:0] reg_addr);
        return a == reg_addr;
    endfunction

    // One decode per register, shared by the write, read and strobe paths
    always_comb begin
        hit_top = tcm_is(cfg_addr, TCM_ADDR_TOP_TEST);
        hit_spare = tcm_is(cfg_addr, TCM_ADDR_SPARE);
        hit_tx = tcm_is(cfg_addr, TCM_ADDR_TX_FIFO);
        hit_rx = tcm_is(cfg_addr, TCM_ADDR_RX_FIFO);
    end

    // ****************************************
    // Register file
    // ****************************************
    logic [15:0] top_level_test_control;
    logic [15:0] spare_control_status;
    logic [15:0] next_top_level_test_control;
    logic [15:0] next_spare_control_status;
    logic [15:0] next_cfg_rdata;
    logic [7:0] next_fifo_wdata;

    // Next register values and read data
    always_comb begin
        next_top_level_test_control = top_level_test_control;
        next_spare_control_status = spare_control_status;
        next_fifo_wdata = fifo_wdata;
        next_cfg_rdata = cfg_rdata;
        if (cfg_wr && hit_top) begin
            next_top_level_test_control = {8'h00, cfg_wdata[7:0]}; // Upper byte reserved
        end
        if (cfg_wr && hit_spare) begin
            next_spare_control_status = cfg_wdata;
        end
        if (cfg_wr && (hit_tx || hit_rx)) begin
            next_fifo_wdata = cfg_wdata[7:0];
        end
        if (cfg_rd) begin
            unique case (1'b1)
                hit_top: next_cfg_rdata = top_level_test_control;
                hit_spare: next_cfg_rdata = spare_control_status;
                hit_rx: next_cfg_rdata = {8'h00, rx_fifo_rdata};
                default: next_cfg_rdata = 16'h0000; // Transmit byte reads as zero
            endcase
        end
    end

    // Register update
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_level_test_control <= TCM_TOP_TEST_RST;
            spare_control_status <= TCM_SPARE_RST;
            cfg_rdata <= 16'h0000;
            fifo_wdata <= 8'h00;
        end else begin
            top_level_test_control <= next_top_level_test_control;
            spare_control_status <= next_spare_control_status;
            cfg_rdata <= next_cfg_rdata;
            fifo_wdata <= next_fifo_wdata;
        end
    end

    // ****************************************
    // FIFO access strobes
    // ****************************************
    logic tx_push_q;
    logic rx_push_q;
    logic rx_pop_q;
    logic next_tx_push;
    logic next_rx_push;
    logic next_rx_pop;

    // One-cycle strobes, data valid with them
    always_comb begin
        next_tx_push = cfg_wr && hit_tx;
        next_rx_push = cfg_wr && hit_rx;
        next_rx_pop = cfg_rd && hit_rx;
    end

    // Strobe registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_push_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_pop_q <= 1'b0;
        end else begin
            tx_push_q <= next_tx_push;
            rx_push_q <= next_rx_push;
            rx_pop_q <= next_rx_pop;
        end
    end

    assign tx_fifo_push = tx_push_q;
    assign rx_fifo_push = rx_push_q;
    assign rx_fifo_pop = rx_pop_q;
    assign cfg_hit = hit_top || hit_spare || hit_tx || hit_rx;

    // ****************************************
    // Test control decode
    // ****************************************
    tcm_analog_s next_analog_ctrl;

    // Analog probe controls for one test register value
    function automatic tcm_analog_s tcm_analog(input logic [15:0] t);
        tcm_analog_s a;
        logic powered;
        powered = !t[TCM_BIT_PROBE_PD];
        a.powered = powered;
        // Mode only acts while powered; codes above 8 do nothing
        a.mode = (powered && t[3:0] <= TCM_PROBE_LAST_MODE) ? t[3:0] : 4'h0;
        a.node_drive = powered && t[3:0] == TCM_PROBE_NODE_MODE
            && t[TCM_BIT_NODE_DRIVE];
        // Pin b leaves as an output while powered, unless it drives the node
        a.pin_b_is_output = powered && !a.node_drive;
        return a;
    endfunction

    // Bit outputs come straight from the register
    always_comb begin
        packet_ram_selftest_go = top_level_test_control[TCM_BIT_SELFTEST];
        battery_probe_out_en = top_level_test_control[TCM_BIT_BATT];
        next_analog_ctrl = tcm_analog(next_top_level_test_control);
    end

    // Analog controls leave on flip-flops, in step with the register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_ctrl <= '0; // Powered down, no mode
        end else begin
            analog_ctrl <= next_analog_ctrl;
        end
    end

    // ****************************************
    // Battery monitor input
    // ****************************************
    logic [2:0] batt_sync;
    logic batt_level;
    logic [2:0] next_batt_sync;
    logic next_batt_level;

    // Comparator output is not clock-aligned; a change counts once stages two and three agree
    always_comb begin
        // Shift in one stage per clock
        next_batt_sync = {batt_sync[1:0], battery_result};
        next_batt_level = batt_level;
        if (batt_sync[1] == batt_sync[2]) begin
            next_batt_level = batt_sync[2];
        end
    end

    // Synchroniser and settled level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            batt_sync <= 3'h0;
            batt_level <= 1'b0;
        end else begin
            batt_sync <= next_batt_sync;
            batt_level <= next_batt_level;
        end
    end

    // ****************************************
    // Test output selectors
    // ****************************************
    // Selector table shared by both pins
    function automatic logic tcm_pick(input logic [4:0] sel, input tcm_probe_s p,
        input logic normal);
        logic v;
        v = 1'b0;
        unique case (sel)
            5'h00: v = normal;
            5'h01: v = p.adc_q_lsb;
            5'h02: v = p.late_resync_pulse;
            5'h03: v = p.lock_status;
            5'h04: v = p.chip_rate_tick;
            5'h05: v = p.bit_rate_tick;
            5'h06: v = p.synth_off;
            5'h07: v = p.converter_off;
            5'h08: v = p.var_gain_amp_off;
            5'h09: v = p.rx_bandpass_off;
            5'h0A: v = p.front_end_off;
            5'h0B: v = p.power_amp_off;
            5'h0C: v = p.gain_loop_tick;
            5'h0D: v = p.stage_peak_flag[0];
            5'h0E: v = p.stage_peak_flag[1];
            5'h0F: v = p.front_gain_level_b1;
            5'h10: v = p.amp_gain_b1;
            5'h11: v = p.peak_reset_n;
            5'h17: v = p.half_rate_clock_out;
            5'h18: v = p.crystal_settled;
            5'h19: v = p.synth_reference_out;
            5'h1A: v = p.synth_divided_out;
            5'h1B: v = p.synth_lock_span;
            5'h1C: v = p.synth_lock_span_sync;
            5'h1D: v = p.adc_clock;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    logic next_assess_pin;
    logic next_delimiter_pin;

    // Pin selection; self-test result replaces delimiter output while running
    always_comb begin
        next_assess_pin = tcm_pick(assess_pin_selector, probe, probe.assess_normal);
        next_delimiter_pin = tcm_pick(delimiter_pin_selector, probe, probe.delimiter_normal);
        if (packet_ram_selftest_go) begin
            next_delimiter_pin = selftest_result;
        end else if (battery_probe_out_en) begin
            next_delimiter_pin = batt_level;
        end
    end

    // Pin flops keep one-cycle pulses one cycle wide
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            assess_pin <= 1'b0;
            frame_delimiter_pin <= 1'b0;
        end else begin
            assess_pin <= next_assess_pin;
            frame_delimiter_pin <= next_delimiter_pin;
        end
    end

endmodule

/* File: test/tcm_properties.sv */
`timescale 1ns/1ps
// ****
// Port checks
// ****
module tcm_checker
    import tcm_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic cfg_wr, // Write
    input wire logic cfg_rd, // Read
    input wire logic [5:0] cfg_addr, // Address
    input wire logic [15:0] cfg_wdata, // Write data
    input wire logic [15:0] cfg_rdata, // Read data
    input wire logic [4:0] assess_pin_selector, // Selector
    input wire tcm_probe_s probe, // Test signals
    input wire logic packet_ram_selftest_go, // Self-test
    input wire tcm_analog_s analog_ctrl, // Analog
    input wire logic tx_fifo_push, // Push
    input wire logic [7:0] fifo_wdata, // FIFO byte
    input wire logic assess_pin // Pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence spare_wr; cfg_wr && cfg_addr == TCM_ADDR_SPARE; endsequence
    sequence spare_rd; cfg_rd && !cfg_wr && cfg_addr == TCM_ADDR_SPARE; endsequence
    sequence top_wr; cfg_wr && cfg_addr == TCM_ADDR_TOP_TEST; endsequence
    sequence resync_in;
        assess_pin_selector == 5'h02 && probe.late_resync_pulse ##1
        assess_pin_selector == 5'h02 && !probe.late_resync_pulse;
    endsequence
    spare_rw_a: assert property (spare_wr ##2 spare_rd |=> cfg_rdata == $past(cfg_wdata, 3))
        else $error("spare readback wrong");
    tx_push_a: assert property (cfg_wr && cfg_addr == TCM_ADDR_TX_FIFO |=> tx_fifo_push &&
        {8'h00, fifo_wdata} == ($past(cfg_wdata) & 16'h00FF)) else $error("tx push wrong");
    tx_read_a: assert property (cfg_rd && cfg_addr == TCM_ADDR_TX_FIFO |=> cfg_rdata == 16'h0000)
        else $error("tx read not zero");
    selftest_a: assert property (top_wr |=> packet_ram_selftest_go == |($past(cfg_wdata) & 16'h0080))
        else $error("self-test bit wrong");
    power_down_a: assert property (top_wr |=> analog_ctrl.powered != |($past(cfg_wdata) & 16'h0010))
        else $error("powerdown bit wrong");
    node_drive_a: assert property (analog_ctrl.node_drive |-> analog_ctrl.powered && analog_ctrl.mode == 4'h7)
        else $error("node drive outside mode 7");
    resync_pulse_a: assert property (resync_in |-> assess_pin ##1 !assess_pin)
        else $error("resync pulse wrong");
    reserved_low_a: assert property (assess_pin_selector inside {[5'h12:5'h16], 5'h1E, 5'h1F} |=> !assess_pin)
        else $error("reserved code not low");
endmodule
bind tcm_test_control tcm_checker u_chk (.clk, .reset_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata,
    .cfg_rdata, .assess_pin_selector, .probe, .packet_ram_selftest_go, .analog_ctrl, .tx_fifo_push,
    .fifo_wdata, .assess_pin);

/* File: test/tcm_pin_watch.sv */
`timescale 1ns/1ps
// ****
// Test equipment on a status pin
// ****
module tcm_pin_watch (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic pin, // Watched pin
    output int rises // Rising levels seen
);
    logic last;
    // Counts rising levels on the pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last <= 1'b0;
            rises <= 0;
        end else begin
            last <= pin;
            rises <= rises + ((pin && !last) ? 1 : 0);
        end
    end
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb;
    import tcm_pkg::*;
    logic clk = 0, reset_n = 0, cfg_wr = 0, cfg_rd = 0, st_res = 0, bat_res = 0;
    logic [5:0] cfg_addr = 0;
    logic [15:0] cfg_wdata = 0, cfg_rdata;
    logic [4:0] asel = 0, dsel = 0;
    logic [7:0] rx_head = 0, fwd;
    logic [31:0] r, r2;
    logic hit, go, bat_en, txp, rxp, rxpop, apin, dpin;
    tcm_probe_s probe = '0;
    tcm_analog_s an;
    int error_cnt = 0, n_checks = 0, cyc = 0, rises, k;
    int txq[$];
    tcm_test_control u_dut (.clk(clk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(hit),
        .assess_pin_selector(asel), .delimiter_pin_selector(dsel), .probe(probe),
        .selftest_result(st_res), .battery_result(bat_res), .rx_fifo_rdata(rx_head),
        .packet_ram_selftest_go(go), .battery_probe_out_en(bat_en), .analog_ctrl(an),
        .tx_fifo_push(txp), .rx_fifo_push(rxp), .rx_fifo_pop(rxpop), .fifo_wdata(fwd),
        .assess_pin(apin), .frame_delimiter_pin(dpin));
    tcm_pin_watch u_watch (.clk(clk), .reset_n(reset_n), .pin(apin), .rises(rises));
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task acc(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
    endtask
    // Expected pin level for a selector code
    function automatic logic pin_exp(input logic [4:0] c, input tcm_probe_s p);
        logic [31:0] v;
        v = {2'b00, p.adc_clock, p.synth_lock_span_sync, p.synth_lock_span, p.synth_divided_out,
            p.synth_reference_out, p.crystal_settled, p.half_rate_clock_out, 5'h00, p.peak_reset_n,
            p.amp_gain_b1, p.front_gain_level_b1, p.stage_peak_flag, p.gain_loop_tick,
            p.power_amp_off, p.front_end_off, p.rx_bandpass_off, p.var_gain_amp_off,
            p.converter_off, p.synth_off, p.bit_rate_tick, p.chip_rate_tick, p.lock_status,
            p.late_resync_pulse, p.adc_q_lsb, p.assess_normal};
        return v[c];
    endfunction
    task results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Clock and hang limit
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            results();
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h86BE));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        acc(0, TCM_ADDR_TOP_TEST, 0);
        chk("top", cfg_rdata, 16'h0010);
        chk("batt", bat_en, 1'b0);
        acc(0, TCM_ADDR_SPARE, 0);
        chk("spare", cfg_rdata, 16'h0000);
        $display("reset test done");
        r = $urandom;
        acc(1, TCM_ADDR_SPARE, r[15:0]);
        acc(0, TCM_ADDR_SPARE, 0);
        chk("spare", cfg_rdata, r[15:0]);
        chk("hit", hit, 1'b1);
        acc(0, 6'h10, 0);
        chk("unmapped", cfg_rdata, 16'h0000);
        chk("hit", hit, 1'b0);
        for (int m = 0; m < 16; m++) begin
            r = $urandom;
            acc(1, TCM_ADDR_TOP_TEST, {8'hA5, r[2:0], 1'b0, m[3:0]});
            chk("go", go, r[2]);
            chk("batt", bat_en, r[1]);
            chk("mode", an.mode, (m <= 8) ? m[3:0] : 4'h0);
            chk("node", an.node_drive, m == 7 && r[0]);
            chk("pinb", an.pin_b_is_output, !(m == 7 && r[0]));
            chk("pwr", an.powered, 1'b1);
        end
        acc(0, TCM_ADDR_TOP_TEST, 0);
        chk("top", cfg_rdata, {8'h00, r[2:0], 5'h0F});
        @(posedge clk);
        st_res <= 1'b1;
        bat_res <= 1'b1;
        acc(1, TCM_ADDR_TOP_TEST, 16'h0090);
        @(posedge clk);
        #1;
        chk("dpin", dpin, 1'b1);
        acc(1, TCM_ADDR_TOP_TEST, 16'h0050);
        @(posedge clk);
        #1;
        chk("dpin", dpin, 1'b1);
        acc(1, TCM_ADDR_TOP_TEST, 16'h0037);
        chk("mode", an.mode, 4'h0);
        chk("node", an.node_drive, 1'b0);
        chk("pwr", an.powered, 1'b0);
        $display("register test done");
        // Crystal taken as running for all FIFO accesses
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            txq.push_back(r[7:0]);
            acc(1, TCM_ADDR_TX_FIFO, r[15:0]);
            chk("txp", txp, 1'b1);
            chk("fwd", fwd, txq.pop_front());
        end
        acc(0, TCM_ADDR_TX_FIFO, 0);
        chk("txrd", cfg_rdata, 16'h0000);
        rx_head <= r[15:8];
        acc(1, TCM_ADDR_RX_FIFO, r[15:0]);
        chk("rxp", {rxp, fwd}, {1'b1, r[7:0]});
        acc(0, TCM_ADDR_RX_FIFO, 0);
        chk("rxrd", cfg_rdata, {8'h00, r[15:8]});
        chk("rxpop", rxpop, 1'b1);
        $display("fifo test done");
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            r = $urandom;
            r2 = $urandom;
            asel <= r[4:0];
            dsel <= r[9:5];
            probe <= r2[25:0];
            @(posedge clk);
            #1;
            chk("apin", apin, pin_exp(asel, probe));
            chk("dpin", dpin, dsel == 0 ? probe.delimiter_normal : pin_exp(dsel, probe));
        end
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            asel <= j ? 5'h0C : 5'h02;
            probe <= '0;
            repeat (2) @(posedge clk);
            #1;
            k = rises;
            @(posedge clk);
            probe.late_resync_pulse <= !j[0];
            probe.gain_loop_tick <= j[0];
            @(posedge clk);
            probe <= '0;
            repeat (3) @(posedge clk);
            #1;
            chk("pulses", rises - k, 16'h0001);
        end
        $display("selector test done");
        results();
    end
endmodule
